// >>> rtl/pewc_pkg.sv
// constants for the parallel eeprom host controller
// assumes a 100 mhz system clock and an asynchronous byte-wide eeprom on the pins
package pewc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_LOW_W = 7;
    // timing in ns, us and ms; ns values rounded up to cycles
    localparam int T_ADDR_SETUP_NS = 20;
    localparam int T_STROBE_NS = 100;
    localparam int T_DATA_HOLD_NS = 20;
    localparam int T_READ_ACCESS_NS = 150;
    localparam int T_RECOVER_NS = 50;
    localparam int T_BYTE_LOAD_MAX_US = 100;
    localparam int T_WRITE_CYCLE_MS = 10;
    localparam int CYC_SETUP = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_STROBE = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_HOLD = (T_DATA_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_ACCESS = (T_READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_RECOVER = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
    // byte-load gap, exact in cycles, no rounding
    localparam int CYC_BYTE_LOAD = T_BYTE_LOAD_MAX_US * CLK_MHZ;
    localparam int CYC_WRITE_CYCLE = T_WRITE_CYCLE_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;
    // command words, arbitrary defaults
    localparam logic [15:0] CMD_A1 = 16'h5555;
    localparam logic [15:0] CMD_A2 = 16'h2aaa;
    localparam logic [7:0] CMD_D1 = 8'haa;
    localparam logic [7:0] CMD_D2 = 8'h55;
    localparam logic [7:0] CMD_LOCK = 8'ha0;
    localparam logic [7:0] CMD_RST4 = 8'h80;
    localparam logic [7:0] CMD_RST6 = 8'h20;
    localparam logic [7:0] POLL_BIT = 8'h80;
    localparam logic [7:0] TOGGLE_BIT = 8'h40;
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_PROT_WRITE = 3'h2;
    localparam logic [2:0] OP_UNPROTECT = 3'h3;
    localparam logic [2:0] OP_POLL = 3'h4;
endpackage

// >>> rtl/pewc_cycle.sv
// one asynchronous bus cycle (read or write) on the eeprom pins
// assumes pin data input is already synchronised by the caller
`timescale 1ns/10ps
module pewc_cycle
    import pewc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [DATA_W-1:0] i_pin_data,
    output logic o_done,
    output logic [DATA_W-1:0] o_rdata,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_data_out,
    output logic o_data_oe,
    output logic o_chip_select_n,
    output logic o_write_strobe_n,
    output logic o_output_drive_n
);
    typedef enum logic [2:0] {
        CY_IDLE = 3'b000,
        CY_SETUP = 3'b001,
        CY_STROBE = 3'b010,
        CY_HOLD = 3'b011,
        CY_RECOVER = 3'b100
    } pewc_cy_e;

    pewc_cy_e state_r;
    logic [7:0] cnt_r;
    logic wr_r;

    always_ff @(posedge i_mclk) begin
        o_done <= 1'b0;
        if (i_srst) begin
            state_r <= CY_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            o_rdata <= 8'h00;
            o_addr <= 16'h0000;
            o_data_out <= 8'h00;
            o_data_oe <= 1'b0;
            o_chip_select_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_output_drive_n <= 1'b1;
        end else begin
            unique case (state_r)
                CY_IDLE: begin
                    if (i_start) begin
                        // address set before any strobe falls
                        o_addr <= i_addr;
                        o_data_out <= i_wdata;
                        wr_r <= i_write;
                        o_chip_select_n <= 1'b0;
                        cnt_r <= 8'(CYC_SETUP);
                        state_r <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    if (cnt_r <= 8'h01) begin
                        if (wr_r) begin
                            // oe held high, we is the later falling edge
                            o_output_drive_n <= 1'b1;
                            o_write_strobe_n <= 1'b0;
                            o_data_oe <= 1'b1;
                            cnt_r <= 8'(CYC_STROBE);
                        end else begin
                            o_output_drive_n <= 1'b0;
                            cnt_r <= 8'(CYC_ACCESS);
                        end
                        state_r <= CY_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                CY_STROBE: begin
                    if (cnt_r <= 8'h01) begin
                        if (wr_r) begin
                            // we rises first, data still held
                            o_write_strobe_n <= 1'b1;
                        end else begin
                            o_rdata <= i_pin_data;
                            o_output_drive_n <= 1'b1;
                        end
                        cnt_r <= 8'(CYC_HOLD);
                        state_r <= CY_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                CY_HOLD: begin
                    if (cnt_r <= 8'h01) begin
                        o_chip_select_n <= 1'b1;
                        o_data_oe <= 1'b0;
                        cnt_r <= 8'(CYC_RECOVER);
                        state_r <= CY_RECOVER;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                CY_RECOVER: begin
                    if (cnt_r <= 8'h01) begin
                        o_done <= 1'b1;
                        state_r <= CY_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: state_r <= CY_IDLE;
            endcase
        end
    end
endmodule

// >>> rtl/pewc_host.sv
// host controller for a byte-wide parallel eeprom: reads, byte/page writes,
// protected writes, protection reset and completion polling
// assumes the eeprom sits directly on the pin ports; data pins pass four flops
`timescale 1ns/10ps
module pewc_host
    import pewc_pkg::*;
#(
    parameter int WRITE_CYCLE_CYC = CYC_WRITE_CYCLE,
    parameter logic [15:0] CMD_ADDR1 = CMD_A1,
    parameter logic [15:0] CMD_ADDR2 = CMD_A2
)
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_req_valid,
    input wire logic [2:0] i_req_op,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic [DATA_W-1:0] i_req_data,
    input wire logic i_req_last,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [DATA_W-1:0] o_rsp_data,
    output logic o_rsp_error,
    input wire logic [DATA_W-1:0] i_data_lines,
    output logic [DATA_W-1:0] o_data_lines,
    output logic o_data_lines_oe,
    output logic [ADDR_W-1:0] o_byte_address,
    output logic o_chip_select_n,
    output logic o_write_strobe_n,
    output logic o_output_drive_n
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_CMD = 3'b001,
        HS_DATA = 3'b010,
        HS_PAGE = 3'b011,
        HS_POLL = 3'b100,
        HS_WAIT = 3'b101
    } pewc_hs_e;

    pewc_hs_e state_r;
    logic [DATA_W-1:0] din_s1_r, din_s2_r, din_s3_r, din_r;
    logic cy_start_r, cy_write_r, cy_done;
    logic [ADDR_W-1:0] cy_addr_r;
    logic [DATA_W-1:0] cy_wdata_r, cy_rdata;
    logic [2:0] step_r, step_last_r;
    logic [ADDR_W-PAGE_LOW_W-1:0] page_r;
    logic [7:0] count_r;
    logic [CNT_W-1:0] tmr_r;
    logic [DATA_W-1:0] last_data_r, poll_prev_r;
    logic poll_first_r;

    function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(input logic [2:0] step,
                                                       input logic unprot);
        // unlock: 3 writes; reset: 6 writes
        unique case (step)
            3'd0: cmd_word = {CMD_ADDR1, CMD_D1};
            3'd1: cmd_word = {CMD_ADDR2, CMD_D2};
            3'd2: cmd_word = {CMD_ADDR1, unprot ? CMD_RST4 : CMD_LOCK};
            3'd3: cmd_word = {CMD_ADDR1, CMD_D1};
            3'd4: cmd_word = {CMD_ADDR2, CMD_D2};
            default: cmd_word = {CMD_ADDR1, CMD_RST6};
        endcase
    endfunction

    // data pins cross from the device: three flops, then din_r loads only when the last two agree
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
            din_s3_r <= 8'h00;
            din_r <= 8'h00;
        end else begin
            din_s1_r <= i_data_lines;
            din_s2_r <= din_s1_r;
            din_s3_r <= din_s2_r;
            if (din_s2_r == din_s3_r) din_r <= din_s3_r;
        end
    end

    pewc_cycle u_cycle (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_start(cy_start_r),
        .i_write(cy_write_r),
        .i_addr(cy_addr_r),
        .i_wdata(cy_wdata_r),
        .i_pin_data(din_r),
        .o_done(cy_done),
        .o_rdata(cy_rdata),
        .o_addr(o_byte_address),
        .o_data_out(o_data_lines),
        .o_data_oe(o_data_lines_oe),
        .o_chip_select_n(o_chip_select_n),
        .o_write_strobe_n(o_write_strobe_n),
        .o_output_drive_n(o_output_drive_n)
    );

    always_ff @(posedge i_mclk) begin
        cy_start_r <= 1'b0;
        o_rsp_valid <= 1'b0;
        if (i_srst) begin
            state_r <= HS_IDLE;
            cy_write_r <= 1'b0;
            cy_addr_r <= 16'h0000;
            cy_wdata_r <= 8'h00;
            step_r <= 3'h0;
            step_last_r <= 3'h0;
            page_r <= 9'h000;
            count_r <= 8'h00;
            tmr_r <= '0;
            last_data_r <= 8'h00;
            poll_prev_r <= 8'h00;
            poll_first_r <= 1'b0;
            o_req_ready <= 1'b0;
            o_rsp_data <= 8'h00;
            o_rsp_error <= 1'b0;
        end else begin
            unique case (state_r)
                HS_IDLE: begin
                    o_req_ready <= 1'b1;
                    if (i_req_valid && o_req_ready) begin
                        o_req_ready <= 1'b0;
                        o_rsp_error <= 1'b0;
                        cy_addr_r <= i_req_addr;
                        cy_wdata_r <= i_req_data;
                        step_r <= 3'h0;
                        count_r <= 8'h00;
                        poll_first_r <= 1'b1;
                        unique case (i_req_op)
                            OP_READ: begin
                                cy_write_r <= 1'b0;
                                cy_start_r <= 1'b1;
                                state_r <= HS_POLL;
                                poll_first_r <= 1'b0;
                            end
                            OP_WRITE: begin
                                // plain write, device unprotected
                                cy_write_r <= 1'b1;
                                cy_start_r <= 1'b1;
                                page_r <= i_req_addr[15:7];
                                state_r <= HS_DATA;
                            end
                            OP_PROT_WRITE, OP_UNPROTECT: begin
                                cy_write_r <= 1'b1;
                                step_last_r <= (i_req_op == OP_UNPROTECT) ? 3'd5 : 3'd2;
                                {cy_addr_r, cy_wdata_r} <= cmd_word(3'd0,
                                    i_req_op == OP_UNPROTECT);
                                cy_start_r <= 1'b1;
                                page_r <= i_req_addr[15:7];
                                state_r <= HS_CMD;
                            end
                            OP_POLL: begin
                                cy_write_r <= 1'b0;
                                cy_start_r <= 1'b1;
                                state_r <= HS_POLL;
                            end
                            default: begin
                                o_rsp_error <= 1'b1;
                                o_rsp_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                HS_CMD: begin
                    // command writes back to back, no other access
                    if (cy_done) begin
                        if (step_r == step_last_r) begin
                            if (step_last_r == 3'd5) begin
                                // wait one write cycle time after reset
                                tmr_r <= CNT_W'(WRITE_CYCLE_CYC);
                                state_r <= HS_WAIT;
                            end else begin
                                // data follows unlock: page of 1..128
                                cy_addr_r <= i_req_addr;
                                cy_wdata_r <= i_req_data;
                                cy_start_r <= 1'b1;
                                state_r <= HS_DATA;
                            end
                        end else begin
                            {cy_addr_r, cy_wdata_r} <= cmd_word(step_r + 3'd1,
                                step_last_r == 3'd5);
                            step_r <= step_r + 3'd1;
                            cy_start_r <= 1'b1;
                        end
                    end
                end
                HS_DATA: begin
                    if (cy_done) begin
                        last_data_r <= cy_wdata_r;
                        count_r <= count_r + 8'h01;
                        // gap counted from the falling edge of last load
                        tmr_r <= CNT_W'(CYC_BYTE_LOAD - CYC_STROBE - CYC_HOLD
                                        - CYC_RECOVER - 2);
                        o_req_ready <= !i_req_last;
                        state_r <= HS_PAGE;
                    end
                end
                HS_PAGE: begin
                    if (i_req_valid && o_req_ready && count_r < 8'(PAGE_BYTES)) begin
                        o_req_ready <= 1'b0;
                        if (i_req_addr[15:7] != page_r) begin
                            // outside page: refuse, close page
                            o_rsp_error <= 1'b1;
                        end else begin
                            cy_addr_r <= i_req_addr;
                            cy_wdata_r <= i_req_data;
                            cy_start_r <= 1'b1;
                            state_r <= HS_DATA;
                        end
                    end else if (tmr_r == '0 || i_req_last || count_r == 8'(PAGE_BYTES)) begin
                        // device closes page after silence and programs
                        o_req_ready <= 1'b0;
                        tmr_r <= CNT_W'(WRITE_CYCLE_CYC);
                        state_r <= HS_WAIT;
                    end else begin
                        tmr_r <= tmr_r - CNT_W'(1);
                    end
                end
                HS_WAIT: begin
                    if (tmr_r == '0) begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= last_data_r;
                        state_r <= HS_IDLE;
                    end else begin
                        tmr_r <= tmr_r - CNT_W'(1);
                    end
                end
                HS_POLL: begin
                    if (cy_done) begin
                        if (!poll_first_r) begin
                            o_rsp_valid <= 1'b1;
                            o_rsp_data <= cy_rdata;
                            state_r <= HS_IDLE;
                        end else begin
                            poll_prev_r <= cy_rdata;
                            poll_first_r <= 1'b0;
                            cy_start_r <= 1'b1;
                            // still programming: bit 6 flips or bit 7 inverted
                            if (((cy_rdata ^ poll_prev_r) & TOGGLE_BIT) == 8'h00 &&
                                count_r != 8'h00 &&
                                ((cy_rdata ^ cy_wdata_r) & POLL_BIT) == 8'h00) begin
                                o_rsp_valid <= 1'b1;
                                o_rsp_data <= cy_rdata;
                                cy_start_r <= 1'b0;
                                state_r <= HS_IDLE;
                            end
                            count_r <= 8'h01;
                            poll_first_r <= 1'b1;
                        end
                    end
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end
endmodule

// >>> testbench/pewc_host_properties.sv
// pin and handshake checks for the eeprom host controller
// assumes it is bound into pewc_host; one clock, synchronous reset
`timescale 1ns/10ps
module pewc_host_props
    import pewc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_req_valid,
    input wire logic [2:0] i_req_op,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_error,
    input wire logic [DATA_W-1:0] o_data_lines,
    input wire logic o_data_lines_oe,
    input wire logic [ADDR_W-1:0] o_byte_address,
    input wire logic o_chip_select_n,
    input wire logic o_write_strobe_n,
    input wire logic o_output_drive_n
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    property p_no_fight;
        o_data_lines_oe |-> o_output_drive_n;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("data driven during read");
    property p_wr_levels;
        !o_write_strobe_n |-> o_output_drive_n && o_data_lines_oe;
    endproperty
    a_wr_levels: assert property (p_wr_levels)
        else $error("write strobe low with bad levels");
    property p_strobe_width;
        $fell(o_write_strobe_n) |-> !o_write_strobe_n [*8];
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("write strobe pulse too short");
    property p_addr_hold;
        (!o_chip_select_n && !o_write_strobe_n) ##1 (!o_chip_select_n && !o_write_strobe_n)
            |-> $stable(o_byte_address) && $stable(o_data_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address or data moved in write");
    property p_data_at_rise;
        $rose(o_write_strobe_n) |-> o_data_lines_oe && $stable(o_data_lines);
    endproperty
    a_data_at_rise: assert property (p_data_at_rise)
        else $error("data not held at strobe rise");
    property p_read_start;
        $fell(o_output_drive_n) |-> o_write_strobe_n && !o_data_lines_oe;
    endproperty
    a_read_start: assert property (p_read_start)
        else $error("read start with write levels");
    property p_take_select;
        i_req_valid && o_req_ready && i_req_op <= OP_POLL |-> ##[1:4] !o_chip_select_n;
    endproperty
    a_take_select: assert property (p_take_select)
        else $error("no chip select after request taken");
    property p_one_op;
        i_req_valid && o_req_ready |=> !o_req_ready;
    endproperty
    a_one_op: assert property (p_one_op)
        else $error("ready held after take");
    property p_rsp_pulse;
        o_rsp_valid |=> !o_rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response valid too long");
    c_write: cover property ($fell(o_write_strobe_n));
    c_read: cover property ($fell(o_output_drive_n));
    c_err: cover property (o_rsp_valid && o_rsp_error);
    c_ok: cover property (o_rsp_valid && !o_rsp_error);
endmodule

// >>> testbench/pewc_eeprom_model.sv
// behavioural byte-wide eeprom: page loads, timed programming, polling, protection
// assumes pins sampled on the bench clock; host misuse counted on o_viol
`timescale 1ns/10ps
module pewc_eeprom_model
    import pewc_pkg::*;
#(
    parameter int LOAD_CYC = 10000,
    parameter int PROG_CYC = 200
)
(
    input wire logic i_mclk,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq,
    output logic o_prot,
    output logic o_idle,
    output logic [7:0] o_viol
);
    logic [7:0] mem [int];
    logic [7:0] pend [int];
    logic [15:0] wa_r = '0, pg_r = '0;
    logic [7:0] last_r = '0, dq_r = '0, viol_r = '0;
    logic wr_r = 1'b0, rd_r = 1'b0, tog_r = 1'b0, open_r = 1'b0, unl_r = 1'b0, clr_r = 1'b0;
    logic prot_r = 1'b0;
    int fall_r = 0, prog_r = 0, step_r = 0;
    logic wr, rd, two;
    assign wr = !i_cs_n && !i_we_n && i_oe_n;
    assign rd = !i_cs_n && !i_oe_n;
    assign two = (step_r == 1 || step_r == 4);
    assign o_dq = dq_r;
    assign o_prot = prot_r;
    assign o_idle = !open_r && prog_r == 0;
    assign o_viol = viol_r;
    always @(posedge i_mclk) begin
        if (wr && !wr_r) begin
            wa_r = i_addr;
            fall_r = 0;
            if (prog_r > 0) viol_r++;
        end else begin
            fall_r++;
        end
        if (!wr && wr_r && prog_r == 0) begin
            if (step_r == 2 && wa_r == CMD_A1 && i_dq == CMD_LOCK) begin
                prot_r = 1'b1;
                unl_r = 1'b1;
                step_r = 0;
            end else if (step_r == 2 && wa_r == CMD_A1 && i_dq == CMD_RST4) begin
                step_r = 3;
            end else if (step_r != 2 && wa_r == (two ? CMD_A2 : CMD_A1)
                && i_dq == (two ? CMD_D2 : (step_r == 5 ? CMD_RST6 : CMD_D1))) begin
                step_r++;
                if (step_r == 6) begin
                    clr_r = 1'b1;
                    prog_r = PROG_CYC;
                    step_r = 0;
                end
            end else begin
                if (step_r != 0) viol_r++;
                step_r = 0;
                if (!prot_r || unl_r) begin
                    if (open_r && wa_r[15:7] != pg_r[15:7]) viol_r++;
                    if (!open_r) pg_r = wa_r;
                    open_r = 1'b1;
                    pend[32'(wa_r)] = i_dq;
                    last_r = i_dq;
                end
            end
        end
        if (open_r && !wr && fall_r >= LOAD_CYC) begin
            foreach (pend[k]) mem[k] = pend[k];
            pend.delete();
            open_r = 1'b0;
            unl_r = 1'b0;
            prog_r = PROG_CYC;
        end else if (prog_r > 0) begin
            prog_r--;
            if (prog_r == 0) prot_r = prot_r && !clr_r;
            if (prog_r == 0) clr_r = 1'b0;
        end
        if (rd && !rd_r) tog_r = !tog_r;
        // released bus shows a moving pattern
        if (!rd) dq_r <= ~dq_r;
        else if (!o_idle) dq_r <= {~last_r[7], tog_r, last_r[5:0]};
        else dq_r <= mem.exists(32'(i_addr)) ? mem[32'(i_addr)] : 8'hff;
        wr_r = wr;
        rd_r = rd;
    end
endmodule

// >>> testbench/parallel_eeprom_write_control_tb_top.sv
// self-checking bench for the eeprom host controller against a slow device model
// assumes the package constants; random values from a fixed seed
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module parallel_eeprom_write_control_tb_top
    import pewc_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    logic [2:0] req_op = '0;
    logic [15:0] req_addr = '0;
    logic [7:0] req_data = '0;
    logic req_last = 1'b0;
    logic req_ready, rsp_valid, rsp_error, h_oe, cs_n, we_n, oe_n, m_prot, m_idle;
    logic [7:0] rsp_data, h_dq, m_dq, dq_w, m_viol;
    logic [15:0] byte_addr;
    logic [7:0] shadow [int];
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    assign dq_w = h_oe ? h_dq : m_dq;
    always #5 mclk = ~mclk;
    pewc_host #(.WRITE_CYCLE_CYC(50)) uut (.i_mclk(mclk), .i_srst(srst),
        .i_req_valid(req_valid), .i_req_op(req_op), .i_req_addr(req_addr),
        .i_req_data(req_data), .i_req_last(req_last), .o_req_ready(req_ready),
        .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_rsp_error(rsp_error),
        .i_data_lines(dq_w), .o_data_lines(h_dq), .o_data_lines_oe(h_oe),
        .o_byte_address(byte_addr), .o_chip_select_n(cs_n), .o_write_strobe_n(we_n),
        .o_output_drive_n(oe_n));
    pewc_eeprom_model #(.LOAD_CYC(CYC_BYTE_LOAD), .PROG_CYC(200)) dev (.i_mclk(mclk),
        .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(byte_addr), .i_dq(dq_w),
        .o_dq(m_dq), .o_prot(m_prot), .o_idle(m_idle), .o_viol(m_viol));
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        return shadow.exists(32'(a)) ? shadow[32'(a)] : 8'hff;
    endfunction
    function automatic logic [15:0] rnd_addr();
        return 16'h8000 | 16'($urandom);
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic send(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d,
        input logic lst);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        req_last <= lst;
        do @(posedge mclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
    endtask
    task automatic wait_rsp(output logic [7:0] d, output logic e);
        while (rsp_valid !== 1'b1) @(posedge mclk);
        d = rsp_data;
        e = rsp_error;
    endtask
    task automatic op1(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] r, output logic e);
        send(op, a, d, 1'b1);
        wait_rsp(r, e);
    endtask
    task automatic chk_rd(input logic [15:0] a);
        logic [7:0] r;
        logic e;
        op1(OP_READ, a, 8'h00, r, e);
        `CHK(r, exp_rd(a))
    endtask
    task automatic wr_poll(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        op1(op, a, d, r, e);
        op1(OP_POLL, a, d, r, e);
        `CHK(r, d)
    endtask
    task automatic wait_idle();
        while (m_idle !== 1'b1) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc >= 100000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        logic [15:0] a, pg;
        logic [7:0] d, r;
        logic e;
        void'($urandom(32'h980d));
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 4; i++) chk_rd(rnd_addr());
        $display("test erased_read done");
        a = rnd_addr();
        d = 8'($urandom);
        shadow[32'(a)] = d;
        wr_poll(OP_WRITE, a, d);
        chk_rd(a);
        $display("test byte_write done");
        pg = rnd_addr() & 16'hff80;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            d = 8'($urandom);
            shadow[32'(pg) + i] = d;
            send(OP_WRITE, pg + 16'(i), d, i == PAGE_BYTES - 1);
        end
        wait_rsp(r, e);
        op1(OP_POLL, pg + 16'(PAGE_BYTES - 1), d, r, e);
        `CHK(r, d)
        for (int i = 0; i < PAGE_BYTES; i++) chk_rd(pg + 16'(i));
        $display("test full_page done");
        for (int k = 5; k < 8; k++) begin
            op1(3'(k), rnd_addr(), 8'h00, r, e);
            `CHK(e, 1'b1)
        end
        $display("test bad_op done");
        a = rnd_addr();
        d = 8'($urandom);
        shadow[32'(a)] = d;
        wr_poll(OP_PROT_WRITE, a, d);
        chk_rd(a);
        `CHK(m_prot, 1'b1)
        chk_rd(CMD_A1);
        chk_rd(CMD_A2);
        a = rnd_addr();
        op1(OP_WRITE, a, 8'($urandom), r, e);
        wait_idle();
        chk_rd(a);
        $display("test protect done");
        op1(OP_UNPROTECT, 16'h0000, 8'h00, r, e);
        wait_idle();
        `CHK(m_prot, 1'b0)
        a = rnd_addr();
        d = 8'($urandom);
        shadow[32'(a)] = d;
        wr_poll(OP_WRITE, a, d);
        chk_rd(a);
        `CHK(m_viol, 8'h00)
        $display("test unprotect done");
        test_done();
    end
endmodule
bind pewc_host pewc_host_props u_props (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_req_valid(i_req_valid), .i_req_op(i_req_op), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_error(o_rsp_error), .o_data_lines(o_data_lines),
    .o_data_lines_oe(o_data_lines_oe), .o_byte_address(o_byte_address),
    .o_chip_select_n(o_chip_select_n), .o_write_strobe_n(o_write_strobe_n),
    .o_output_drive_n(o_output_drive_n));
